// file: rtl/rcd_top.v
// Behaviour
// - The system clock aclk is the only source of the reference clock.
// - The divided clock also feeds the modulator as an internal clock.
// - The divider runs only while the module enable bit 7 is set.
// - The pin carries the reference clock only when pin enable bit 6 is set.
// - A three-bit field in bits 2 to 0 selects one of eight ratios.
// - Code 000 passes the base clock unchanged, unless 0% duty is chosen.
// - At divide by two, 25% and 75% duty are only approximate.
// - Duty select field in bits 4 to 3 shapes the output high time.
// - Bit 5 set limits pin slew rate; clearing it removes the limit.
// - Reset disables the module and restores register defaults; firmware reinitialises.
// - Crystal oscillator modes keep the shared pin as an oscillator input.
// - Instruction clock control 0 drives Fosc/4 on the pin unless a crystal oscillator mode is set.
// - A pin conflict still lets the module run for the modulator.
// - In sleep the module stops and outputs hold their levels.
//
// Register access over AXI4-Lite and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "rcd_consts.vh"

module rcd_top (
  input  wire                   aclk,
  input  wire                   aresetn,
  // AXI4-Lite slave.
  input  wire [`RCD_ADDR_W-1:0] s_axi_awaddr,
  input  wire [2:0]             s_axi_awprot,
  input  wire                   s_axi_awvalid,
  output wire                   s_axi_awready,
  input  wire [31:0]            s_axi_wdata,
  input  wire [3:0]             s_axi_wstrb,
  input  wire                   s_axi_wvalid,
  output wire                   s_axi_wready,
  output reg  [1:0]             s_axi_bresp,
  output reg                    s_axi_bvalid,
  input  wire                   s_axi_bready,
  input  wire [`RCD_ADDR_W-1:0] s_axi_araddr,
  input  wire [2:0]             s_axi_arprot,
  input  wire                   s_axi_arvalid,
  output wire                   s_axi_arready,
  output reg  [31:0]            s_axi_rdata,
  output reg  [1:0]             s_axi_rresp,
  output reg                    s_axi_rvalid,
  input  wire                   s_axi_rready,
  // Configuration and power state, all from logic on aclk.
  input  wire                   crystal_low_power_mode,
  input  wire                   crystal_mode,
  input  wire                   crystal_high_speed_mode,
  input  wire                   instr_clock_out_control,
  input  wire                   sleep_mode,
  // Internal clock to the modulator.
  output wire                   ref_clock_to_modulator,
  // Shared oscillator pin.
  output wire                   oscillator_pin_two_out,
  output wire                   oscillator_pin_two_oe,
  output wire                   ref_slew_limit_enable
);

  // =====================================================================
  // Control register and decoded fields.
  // =====================================================================
  reg  [7:0] reference_clock_control;
  wire       ref_module_enable;
  wire       ref_pin_output_enable;
  wire [1:0] ref_duty_select;
  wire [2:0] ref_divider_select;

  assign ref_module_enable     = reference_clock_control[`RCD_CTRL_EN_BIT];
  assign ref_pin_output_enable = reference_clock_control[`RCD_CTRL_OE_BIT];
  assign ref_duty_select       = reference_clock_control[`RCD_CTRL_DUTY_HI:`RCD_CTRL_DUTY_LO];
  assign ref_divider_select    = reference_clock_control[`RCD_CTRL_DIV_HI:`RCD_CTRL_DIV_LO];

  // =====================================================================
  // Bus slave: write path.
  // =====================================================================
  reg                   aw_held;
  reg [`RCD_ADDR_W-1:0] aw_addr;
  reg                   w_held;
  reg [31:0]            w_data;
  reg [3:0]             w_strb;
  wire                  do_write;
  wire                  ctrl_write;

  // Each channel is taken once and parked until the response leaves.
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;
  assign ctrl_write    = do_write && (aw_addr == `RCD_CTRL_ADDR) && w_strb[0];

  // Address and data capture, in either order.
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= {`RCD_ADDR_W{1'b0}};
      w_held  <= 1'b0;
      w_data  <= 32'h00000000;
      w_strb  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  // Write response; the status word is read only and refuses writes.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RCD_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (aw_addr == `RCD_CTRL_ADDR) ? `RCD_RESP_OKAY : `RCD_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control register; only byte lane 0 holds bits.
  always @(posedge aclk) begin
    if (!aresetn) begin
      reference_clock_control <= `RCD_CTRL_RESET;
    end else if (ctrl_write) begin
      reference_clock_control <= w_data[7:0];
    end
  end

  // =====================================================================
  // Clock generation.
  // =====================================================================
  wire shaped;
  wire bypass;
  wire bypass_clock;
  reg  sleep_gate;

  // Sleep freeze
  // The bypass path samples aclk directly, so its level is latched at sleep entry.
  always @(posedge aclk) begin
    if (!aresetn) begin
      sleep_gate <= 1'b0;
    end else begin
      sleep_gate <= sleep_mode;
    end
  end

  rcd_divider u_divider (
    .aclk               (aclk),
    .aresetn            (aresetn),
    .run                (ref_module_enable),
    .hold               (sleep_mode),
    .restart            (ctrl_write),
    .ref_divider_select (ref_divider_select),
    .ref_duty_select    (ref_duty_select),
    .shaped             (shaped)
  );

  // Base clock bypass
  // Code 000 forwards aclk through a gate; it keeps the source duty for any nonzero duty select.
  assign bypass       = (ref_divider_select == 3'h0);
  // Sleep forces the gated clock high, matching aclk's level at the sleep edge.
  assign bypass_clock = ref_module_enable && (ref_duty_select != `RCD_DUTY_0) && (aclk || sleep_gate);

  assign ref_clock_to_modulator = bypass ? bypass_clock : shaped;

  // =====================================================================
  // Instruction clock, Fosc/4 for the shared pin.
  // =====================================================================
  reg [1:0] quarter_cnt;
  reg       instr_clock_out_function;

  // Free-running quarter divider, square output.
  always @(posedge aclk) begin
    if (!aresetn) begin
      quarter_cnt              <= 2'h0;
      instr_clock_out_function <= 1'b0;
    end else if (!sleep_mode) begin
      quarter_cnt              <= quarter_cnt + 2'h1;
      instr_clock_out_function <= (quarter_cnt == 2'h1) || (quarter_cnt == 2'h2);
    end
  end

  // =====================================================================
  // Shared pin arbitration.
  // =====================================================================
  wire crystal_sel;
  wire pin_instr;
  wire pin_ref;

  assign crystal_sel = crystal_low_power_mode || crystal_mode || crystal_high_speed_mode;
  assign pin_instr   = !crystal_sel && !instr_clock_out_control;
  assign pin_ref     = !crystal_sel && instr_clock_out_control && ref_pin_output_enable && ref_module_enable;

  assign oscillator_pin_two_oe  = pin_instr || pin_ref;
  assign oscillator_pin_two_out = pin_instr ? instr_clock_out_function : (pin_ref && ref_clock_to_modulator);
  assign ref_slew_limit_enable  = reference_clock_control[`RCD_CTRL_SLEW_BIT];

  // =====================================================================
  // Bus slave: read path.
  // =====================================================================
  wire [7:0] status_word;

  assign status_word = {4'h0, pin_instr,
                        crystal_sel || !instr_clock_out_control,
                        pin_ref, ref_module_enable};
  assign s_axi_arready = !s_axi_rvalid;

  // Read data one cycle after the address is taken.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `RCD_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      case (s_axi_araddr)
        `RCD_CTRL_ADDR: begin
          s_axi_rdata <= {24'h000000, reference_clock_control};
          s_axi_rresp <= `RCD_RESP_OKAY;
        end
        `RCD_STAT_ADDR: begin
          s_axi_rdata <= {24'h000000, status_word};
          s_axi_rresp <= `RCD_RESP_OKAY;
        end
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `RCD_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // rcd_top

`default_nettype wire

// file: pkg/rcd_consts.vh
// =====================================================================
// Register map and field layout of the reference clock divider.
// =====================================================================
`ifndef RCD_CONSTS_VH
`define RCD_CONSTS_VH

// Bus address width in bits, byte addressed.
`define RCD_ADDR_W          4

// =====================================================================
// Register offsets.
// =====================================================================
`define RCD_CTRL_ADDR       4'h0
`define RCD_STAT_ADDR       4'h4

// =====================================================================
// Control register fields.
// =====================================================================
`define RCD_CTRL_RESET      8'h30
`define RCD_CTRL_EN_BIT     7
`define RCD_CTRL_OE_BIT     6
`define RCD_CTRL_SLEW_BIT   5
`define RCD_CTRL_DUTY_HI    4
`define RCD_CTRL_DUTY_LO    3
`define RCD_CTRL_DIV_HI     2
`define RCD_CTRL_DIV_LO     0

// =====================================================================
// Status register fields.
// =====================================================================
`define RCD_STAT_RUN_BIT    0
`define RCD_STAT_PINREF_BIT 1
`define RCD_STAT_CONFL_BIT  2
`define RCD_STAT_INSTR_BIT  3

// =====================================================================
// Duty select codes.
// =====================================================================
`define RCD_DUTY_0          2'h0
`define RCD_DUTY_25         2'h1
`define RCD_DUTY_50         2'h2
`define RCD_DUTY_75         2'h3

// =====================================================================
// Bus responses.
// =====================================================================
`define RCD_RESP_OKAY       2'h0
`define RCD_RESP_SLVERR     2'h2

`endif

// file: rtl/rcd_divider.v
`timescale 1ns/1ps
`default_nettype none
`include "rcd_consts.vh"

// =====================================================================
// Power-of-two divider with duty shaping for ratios 2 to 128.
// =====================================================================
module rcd_divider (
  input  wire       aclk,
  input  wire       aresetn,
  input  wire       run,
  input  wire       hold,
  input  wire       restart,
  input  wire [2:0] ref_divider_select,
  input  wire [1:0] ref_duty_select,
  output reg        shaped
);

  reg  [6:0] cnt;
  wire [6:0] cnt_mask;
  wire [6:0] next_cnt;

  // High time in aclk cycles for one period; never zero unless duty is 0% or the ratio select is 000.
  function [7:0] high_len;
    input [2:0] div;
    input [1:0] duty;
    reg   [7:0] period;
    begin
      period = 8'h01 << div;
      case (duty)
        `RCD_DUTY_0:  high_len = 8'h00;
        `RCD_DUTY_25: high_len = period >> 2;
        `RCD_DUTY_50: high_len = period >> 1;
        default:      high_len = period - (period >> 2);
      endcase
      // At divide by two a quarter period is below one cycle, so it rounds up.
      if ((duty != `RCD_DUTY_0) && (high_len == 8'h00)) begin
        high_len = 8'h01;
      end
      // At divide by two three quarters would fill the whole period and stop the clock.
      if (high_len >= period) begin
        high_len = period - 8'h01;
      end
    end
  endfunction

  assign cnt_mask = 7'h7f >> (3'h7 - ref_divider_select);
  assign next_cnt = (cnt + 7'h01) & cnt_mask;

  // Counter and registered output; hold freezes both as the halted clock would.
  always @(posedge aclk) begin
    if (!aresetn || !run || restart) begin
      cnt    <= 7'h7f; // Wraps to zero next, so the first high time is a whole one.
      shaped <= 1'b0;
    end else if (!hold) begin
      cnt    <= next_cnt;
      shaped <= ({1'b0, next_cnt} < high_len(ref_divider_select, ref_duty_select));
    end
  end

endmodule // rcd_divider

`default_nettype wire

// file: tb/rcd_clock_probe.sv
`timescale 1ns/1ps
`default_nettype none
// =====
// Far-side probe: measures period and high time between rises.
module rcd_clock_probe (
  input  wire logic       aclk,
  input  wire logic       sig,
  output logic      [7:0] period,
  output logic      [7:0] high_cnt
);
  logic       prev = 1'b0;
  logic [7:0] cnt  = 8'h00;
  logic [7:0] hc   = 8'h00;
  // A rise closes one period, so a stalled clock leaves the last figures.
  always @(posedge aclk) begin
    prev <= sig;
    if (sig && !prev) begin
      period   <= cnt;
      high_cnt <= hc;
      cnt      <= 8'h01;
      hc       <= 8'h01;
    end else begin
      cnt <= cnt + 8'h01;
      hc  <= hc + {7'h00, sig};
    end
  end
endmodule // rcd_clock_probe
`default_nettype wire

// file: tb/rcd_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "rcd_consts.vh"
// =====
// Port checks of the reference clock divider.
module rcd_properties (
  input wire logic                   aclk,
  input wire logic                   aresetn,
  input wire logic [`RCD_ADDR_W-1:0] s_axi_awaddr,
  input wire logic                   s_axi_awvalid,
  input wire logic                   s_axi_awready,
  input wire logic [31:0]            s_axi_wdata,
  input wire logic [3:0]             s_axi_wstrb,
  input wire logic                   s_axi_wvalid,
  input wire logic                   s_axi_wready,
  input wire logic                   s_axi_bvalid,
  input wire logic                   crystal_low_power_mode,
  input wire logic                   crystal_mode,
  input wire logic                   crystal_high_speed_mode,
  input wire logic                   instr_clock_out_control,
  input wire logic                   sleep_mode,
  input wire logic                   ref_clock_to_modulator,
  input wire logic                   oscillator_pin_two_out,
  input wire logic                   oscillator_pin_two_oe,
  input wire logic                   ref_slew_limit_enable
);
  logic [7:0] sh;
  logic [7:0] wd;
  logic [3:0] wa;
  logic       ws;
  logic       bv_d;
  wire        xtal = crystal_low_power_mode | crystal_mode | crystal_high_speed_mode;
  wire        nb   = !s_axi_bvalid;
  // Shadow control value; it is trusted only while no write answer is out.
  always @(posedge aclk) begin
    bv_d <= s_axi_bvalid;
    if (s_axi_awvalid && s_axi_awready) wa <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) wd <= s_axi_wdata[7:0];
    if (s_axi_wvalid && s_axi_wready) ws <= s_axi_wstrb[0];
    if (!aresetn) sh <= `RCD_CTRL_RESET;
    else if (s_axi_bvalid && !bv_d && wa == `RCD_CTRL_ADDR && ws) sh <= wd;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_xtal_pin_off: assert property (xtal |-> !oscillator_pin_two_oe)
    else $error("pin driven in crystal mode");
  a_instr_owns_pin: assert property (!xtal && !instr_clock_out_control |-> oscillator_pin_two_oe)
    else $error("instruction clock not on pin");
  a_pin_ref_gate: assert property (!xtal && instr_clock_out_control && nb |->
    oscillator_pin_two_oe == (sh[7] && sh[6]) && (!oscillator_pin_two_oe || oscillator_pin_two_out == ref_clock_to_modulator))
    else $error("pin enable or level wrong");
  a_disabled_low: assert property (nb && !sh[7] |-> !ref_clock_to_modulator)
    else $error("clock runs while disabled");
  a_zero_duty_low: assert property (nb && sh[4:3] == `RCD_DUTY_0 |-> !ref_clock_to_modulator)
    else $error("clock high at zero duty");
  a_slew_tracks: assert property (nb |-> ref_slew_limit_enable == sh[5])
    else $error("slew limit differs from control");
  a_reset_quiet: assert property ($rose(aresetn) |-> !ref_clock_to_modulator && ref_slew_limit_enable)
    else $error("reset state wrong");
  a_sleep_hold: assert property (sleep_mode && $past(sleep_mode) && nb |-> $stable(ref_clock_to_modulator))
    else $error("clock moved in sleep");
  a_ratio_four: assert property (@(posedge aclk) disable iff (!aresetn || s_axi_bvalid || sleep_mode)
    $rose(ref_clock_to_modulator) && sh[7] && sh[4:0] == 5'h12 |->
    ref_clock_to_modulator[*2] ##1 !ref_clock_to_modulator[*2])
    else $error("divide by four shape wrong");
endmodule // rcd_properties
bind rcd_top rcd_properties u_props (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .crystal_low_power_mode,
  .crystal_mode, .crystal_high_speed_mode, .instr_clock_out_control, .sleep_mode,
  .ref_clock_to_modulator, .oscillator_pin_two_out, .oscillator_pin_two_oe, .ref_slew_limit_enable);
`default_nettype wire

// file: tb/tb_reference_clock_divider.sv
`timescale 1ns/1ps
`default_nettype none
`include "rcd_consts.vh"
module tb_reference_clock_divider;
  localparam logic [1:0] OK = `RCD_RESP_OKAY;
  localparam logic [1:0] ER = `RCD_RESP_SLVERR;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        xlp = 1'b0, xt = 1'b0, xhs = 1'b0, instr = 1'b1, sleep = 1'b0, v;
  wire         awready, wready, bvalid, arready, rvalid, ref_clk, pin_out, pin_oe, slew;
  wire [1:0]   bresp, rresp;
  wire [31:0]  rdata;
  wire [7:0]   m_per, m_hi, p_per, p_hi;
  // The pin has a pull-down, so a released pin reads low.
  wire         pin_seen = pin_oe ? pin_out : 1'b0;
  int          n_errors = 0, checks_done = 0, cyc = 0, p, h;
  rcd_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .crystal_low_power_mode(xlp), .crystal_mode(xt),
    .crystal_high_speed_mode(xhs), .instr_clock_out_control(instr), .sleep_mode(sleep),
    .ref_clock_to_modulator(ref_clk), .oscillator_pin_two_out(pin_out),
    .oscillator_pin_two_oe(pin_oe), .ref_slew_limit_enable(slew));
  rcd_clock_probe u_mod (.aclk(aclk), .sig(ref_clk), .period(m_per), .high_cnt(m_hi));
  rcd_clock_probe u_pin (.aclk(aclk), .sig(pin_seen), .period(p_per), .high_cnt(p_hi));
  always #2 aclk = ~aclk;
  // Hang guard, well above the few thousand cycles the run needs.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      results();
    end
  end
  task automatic results();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // Write: both channels offered together, each released once taken.
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge aclk);
      if (awready && !ta) awvalid <= 1'b0;
      if (wready && !tw) wvalid <= 1'b0;
      ta = ta | awready;
      tw = tw | wready;
    end
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, bresp});
    @(posedge aclk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
    chk("rdata", ed, rdata);
    chk("rresp", {30'h0, er}, {30'h0, rresp});
    @(posedge aclk);
  endtask
  // Main sequence.
  initial begin
    idle(16);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(4'h0, 32'h30, OK);
    rd(4'h8, 32'h0, ER);
    wr(4'h4, 32'h0, ER);
    for (int n = 1; n < 8; n++) begin
      for (int d = 1; d < 4; d++) begin
        p = 1 << n;
        h = (n == 1) ? 1 : p * d / 4;
        wr(4'h0, {24'h0, 3'b111, d[1:0], n[2:0]}, OK);
        idle(3 * p + 8);
        chk("mod period", p, m_per);
        chk("mod high", h, m_hi);
        chk("pin period", p, p_per);
      end
    end
    rd(4'h0, 32'hff, OK);
    rd(4'h4, 32'h3, OK);
    wr(4'h0, 32'hc1, OK);
    idle(12);
    chk("zero duty", 0, ref_clk);
    wr(4'h0, 32'hd2, OK);
    idle(20);
    chk("pin oe", 1, pin_oe);
    chk("slew", 0, slew);
    for (int k = 0; k < 3; k++) begin
      {xlp, xt, xhs} <= 3'b001 << k;
      idle(20);
      chk("xtal oe", 0, pin_oe);
      chk("xtal mod", 4, m_per);
    end
    {xlp, xt, xhs} <= 3'b000;
    instr <= 1'b0;
    idle(20);
    chk("fosc oe", 1, pin_oe);
    chk("fosc period", 4, p_per);
    chk("fosc high", 2, p_hi);
    instr <= 1'b1;
    wr(4'h0, 32'h52, OK);
    idle(12);
    chk("off oe", 0, pin_oe);
    chk("off ref", 0, ref_clk);
    wr(4'h0, 32'hd3, OK);
    idle(13);
    sleep <= 1'b1;
    @(posedge aclk);
    v = ref_clk;
    idle(20);
    chk("sleep hold", v, ref_clk);
    sleep <= 1'b0;
    wr(4'h0, 32'h90, OK);
    @(posedge aclk);
    #1 chk("bypass high", 1, ref_clk);
    #2 chk("bypass low", 0, ref_clk);
    @(posedge aclk);
    aresetn <= 1'b0;
    idle(2);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("reset ref", 0, ref_clk);
    rd(4'h0, 32'h30, OK);
    results();
  end
endmodule // tb_reference_clock_divider
`default_nettype wire
